// ### dv/pdm_far_model.sv
// Far-side model: a core that retires the halt and an interrupt
// controller that holds a request until an interrupt or NMI wake takes it.
// Assumes the same clock as the power-down controller.
`default_nettype none
module pdm_far_model (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic sleep_cmd,
    input  wire logic irq_cmd,
    input  wire logic cpu_halt,
    input  wire logic wake_irq,
    input  wire logic wake_nmi,
    output var  logic halt_exec   = 1'b0,
    output var  logic irq_request = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // A halt retires only while the core runs, and lasts one cycle.
    always @(posedge core_clk) begin
        halt_exec <= !reset && sleep_cmd && !cpu_halt;
        if (reset || wake_irq || wake_nmi) begin
            irq_request <= 1'b0;
        end else if (irq_cmd) begin
            irq_request <= 1'b1;
        end
    end
endmodule : pdm_far_model
`default_nettype wire

// ### dv/pdm_power_ctrl_sva.sv
// Checker for the power-down controller, bound to its top module.
// Assumes one clock and the synchronous active-high reset.
`default_nettype none
module pdm_power_ctrl_sva
    import pdm_pkg::*;
#(
    parameter int SETTLE_BASE_CYC = PDM_SETTLE_BASE_CYC
) (
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       halt_exec,
    input wire logic       cpu_halt,
    input wire logic       irq_request,
    input wire logic       irq_source_enable,
    input wire logic [3:0] irq_level,
    input wire logic [3:0] irq_cpu_mask,
    input wire logic       dma_addr_error,
    input wire logic       external_reset_n,
    input wire logic       nmi_pin,
    input wire logic       clock_stop,
    input wire logic       periph_halt,
    input wire logic       port_float,
    input wire logic       port_hold,
    input wire logic       ram_retain,
    input wire logic       wake_irq,
    input wire logic       wake_dma_error,
    input wire logic       power_on_reset,
    input wire logic       manual_reset,
    input wire logic [1:0] power_state
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // An interrupt the core would accept right now.
    logic acc;
    assign acc = irq_request && irq_source_enable && (irq_level > irq_cpu_mask);
    a_halt_enter: assert property (halt_exec && power_state == 2'b00 && external_reset_n
        |=> cpu_halt && power_state inside {2'b01, 2'b10}) else $error("halt not taken");
    a_sleep_runs: assert property (power_state == 2'b01
        |-> cpu_halt && !periph_halt && !clock_stop) else $error("sleep stops too much");
    a_standby_stops: assert property (power_state == 2'b10
        |-> cpu_halt && clock_stop && periph_halt && ram_retain) else $error("standby runs");
    a_float_hold: assert property (port_float
        |-> power_state[1] && !port_hold) else $error("ports float wrongly");
    a_irq_wakes: assert property (power_state == 2'b01 && acc && !dma_addr_error
        && external_reset_n |=> wake_irq && power_state == 2'b00) else $error("irq no wake");
    a_masked_sleeps: assert property (wake_irq |-> $past(acc))
        else $error("wake without accepted irq");
    a_standby_deaf: assert property (power_state == 2'b10
        |=> !wake_irq && !wake_dma_error) else $error("standby woke on irq or dma");
    a_dma_wakes: assert property (power_state == 2'b01 && dma_addr_error
        && external_reset_n |=> wake_dma_error) else $error("dma error no wake");
    a_por_kind: assert property ($fell(external_reset_n) && nmi_pin
        |-> ##[1:5] power_on_reset) else $error("no power-on reset");
    a_manual_kind: assert property ($fell(external_reset_n) && !nmi_pin
        |-> ##[1:5] manual_reset) else $error("no manual reset");
endmodule : pdm_power_ctrl_sva
bind pdm_power_ctrl pdm_power_ctrl_sva #(.SETTLE_BASE_CYC(SETTLE_BASE_CYC)) chk_inst (
    .core_clk, .reset, .halt_exec, .cpu_halt, .irq_request, .irq_source_enable, .irq_level,
    .irq_cpu_mask, .dma_addr_error, .external_reset_n, .nmi_pin, .clock_stop, .periph_halt,
    .port_float, .port_hold, .ram_retain, .wake_irq, .wake_dma_error, .power_on_reset,
    .manual_reset, .power_state);
`default_nettype wire

// ### dv/pdm_power_ctrl_tb.sv
// Self-checking bench for the power-down controller.
// Assumes the far-side model and the bound checker.
`default_nettype none
module pdm_power_ctrl_tb
    import pdm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BASE = 4; // Short settle base keeps the run brief.
    localparam logic [27:0] A = PDM_STBY_CFG_ADDR;
    logic core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, halt_exec, irq_request;
    logic [27:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0, reg_rdata;
    logic watchdog_run_enable = 0, irq_source_enable = 0, nmi_edge_select = 0;
    logic [2:0] settle_interval_select = 3'h2;
    logic [3:0] irq_level = 4'h0, irq_cpu_mask = 4'h5;
    logic dma_addr_error = 0, external_reset_n = 1, nmi_pin = 0, sleep_cmd = 0, irq_cmd = 0;
    logic cpu_halt, watchdog_clock_only, clock_stop, periph_halt, port_float, port_hold;
    logic ram_retain, wake_irq, wake_dma_error, wake_nmi, power_on_reset, manual_reset;
    logic [1:0] power_state;
    logic [4:0] seen = '0; // Sticky record of wake and reset pulses.
    int n_errors = 0, n_tests = 0;
    pdm_power_ctrl #(.SETTLE_BASE_CYC(BASE)) pdm_power_ctrl_inst (.*);
    pdm_far_model pdm_far_model_inst (.core_clk, .reset, .sleep_cmd, .irq_cmd, .cpu_halt,
        .wake_irq, .wake_nmi, .halt_exec, .irq_request);
    initial forever #10 core_clk = ~core_clk;
    // Pulses last one cycle, so they are caught here; a new halt request clears them.
    always @(posedge core_clk) begin
        seen <= sleep_cmd ? 5'h00 :
                seen | {manual_reset, power_on_reset, wake_nmi, wake_dma_error, wake_irq};
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic wr(input logic [27:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [27:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    task automatic wait_st(input logic [1:0] s);
        for (int i = 0; i < 300 && power_state !== s; i++) tick(1);
        if (power_state !== s) begin
            chk({6'h00, power_state}, {6'h00, s});
            report_and_stop();
        end
        tick(1); // Pulses reach seen one edge after the state moves.
    endtask : wait_st
    task automatic halt_now;
        @(posedge core_clk);
        sleep_cmd <= 1'b1;
        @(posedge core_clk);
        sleep_cmd <= 1'b0;
    endtask : halt_now
    task automatic t_regs;
        chk({4'h0, cpu_halt, clock_stop, port_float, wake_irq}, 8'h00);
        rd(A, 8'h1F);
        wr(A, 8'hFF);
        rd(A, 8'hDF);
        wr(A, 8'h00);
        @(posedge core_clk) watchdog_run_enable <= 1'b1;
        wr(A, 8'h80);
        rd(A, 8'h1F);
        wr(A, 8'h40);
        rd(A, 8'h1F);
        @(posedge core_clk) watchdog_run_enable <= 1'b0;
        rd(28'h5FFFFC0, 8'h00);
        $display("done regs");
    endtask : t_regs
    task automatic t_sleep;
        irq_level <= 4'h5;
        irq_source_enable <= 1'b1;
        halt_now();
        wait_st(2'b01);
        chk({7'h00, periph_halt}, 8'h00);
        @(posedge core_clk) irq_cmd <= 1'b1;
        @(posedge core_clk) irq_cmd <= 1'b0;
        tick(4);
        chk({6'h00, power_state}, 8'h01);
        irq_level <= 4'h6;
        irq_source_enable <= 1'b0;
        tick(4);
        chk({6'h00, power_state}, 8'h01);
        irq_source_enable <= 1'b1;
        wait_st(2'b00);
        chk({3'h0, seen}, 8'h01);
        halt_now();
        wait_st(2'b01);
        @(posedge core_clk) dma_addr_error <= 1'b1;
        @(posedge core_clk) dma_addr_error <= 1'b0;
        wait_st(2'b00);
        chk({3'h0, seen}, 8'h02);
        for (int e = 1; e >= 0; e--) begin
            @(posedge core_clk) nmi_edge_select <= e[0];
            halt_now();
            wait_st(2'b01);
            @(posedge core_clk) nmi_pin <= e[0];
            wait_st(2'b00);
            chk({3'h0, seen}, 8'h04);
        end
        $display("done sleep");
    endtask : t_sleep
    task automatic t_reset_pin;
        for (int p = 1; p >= 0; p--) begin
            @(posedge core_clk) nmi_edge_select <= ~p[0];
            nmi_pin <= p[0];
            tick(6);
            halt_now();
            wait_st(2'b01);
            @(posedge core_clk) external_reset_n <= 1'b0;
            tick(6);
            chk({3'h0, seen}, p[0] ? 8'h08 : 8'h10);
            @(posedge core_clk) external_reset_n <= 1'b1;
            wait_st(2'b00);
        end
        $display("done reset pin");
    endtask : t_reset_pin
    task automatic t_standby(input logic [7:0] cfg);
        int n;
        settle_interval_select <= {1'b0, cfg[6], ~cfg[6]}; // Two intervals are tried.
        wr(A, cfg);
        @(posedge core_clk) nmi_edge_select <= 1'b1;
        halt_now();
        wait_st(2'b10);
        chk({6'h00, port_float, port_hold}, {6'h00, cfg[6], ~cfg[6]});
        @(posedge core_clk) irq_cmd <= 1'b1;
        dma_addr_error <= 1'b1;
        @(posedge core_clk) irq_cmd <= 1'b0;
        dma_addr_error <= 1'b0;
        tick(5);
        chk({6'h00, power_state}, 8'h02);
        @(posedge core_clk) nmi_pin <= 1'b1;
        wait_st(2'b11);
        n = 0;
        while (n < 200 && watchdog_clock_only === 1'b1) begin
            tick(1);
            n++;
        end
        chk(n[7:0], 8'((BASE << settle_interval_select) + 1));
        wait_st(2'b00);
        chk({3'h0, seen}, 8'h04);
        @(posedge core_clk) nmi_pin <= 1'b0;
        tick(4);
        $display("done standby %h", cfg);
    endtask : t_standby
    task automatic report_and_stop;
        $display("comparisons=%0d mismatches=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        tick(2);
        t_regs();
        t_sleep();
        t_reset_pin();
        t_standby(8'hC0);
        t_standby(8'h80);
        report_and_stop();
    end
endmodule : pdm_power_ctrl_tb
`default_nettype wire

// ### src/pdm_pkg.sv
// Shared constants and types for the power-down mode control block.
// Assumes a single 50 MHz system clock and a synchronous, active-high reset.
`default_nettype none

package pdm_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    // Byte address of the standby configuration register.
    localparam logic [27:0] PDM_STBY_CFG_ADDR   = 28'h5FFFFBC;
    // Value of the standby configuration register after reset.
    localparam logic [7:0]  PDM_STBY_CFG_RESET  = 8'h1F;
    // Field positions inside the standby configuration register.
    localparam int          PDM_STANDBY_SEL_BIT = 7;
    localparam int          PDM_PORT_FLOAT_BIT  = 6;
    localparam int          PDM_ZERO_BIT        = 5;
    // Bits 4..0 always read as ones.
    localparam logic [4:0]  PDM_ONES_FIELD      = 5'h1F;
    // Reset values of the two writable fields.
    localparam logic        PDM_STANDBY_SEL_RST = 1'b0;
    localparam logic        PDM_PORT_FLOAT_RST  = 1'b0;

    // ************************************************************
    // Clock settling
    // ************************************************************
    // Watchdog overflow interval at select code 0, in system clock cycles.
    // Each higher select code doubles it.
    localparam int          PDM_SETTLE_BASE_CYC = 256;
    // Width of the settle counter, enough for the base shifted by seven.
    localparam int          PDM_SETTLE_CNT_W    = 16;

    // ************************************************************
    // Power states
    // ************************************************************
    typedef enum logic [1:0] {
        PDM_RUN     = 2'b00,
        PDM_SLEEP   = 2'b01,
        PDM_STANDBY = 2'b10,
        PDM_SETTLE  = 2'b11
    } pdm_state_t;

endpackage : pdm_pkg

`default_nettype wire

// ### src/pdm_power_ctrl.sv
// Power-down mode controller: standby configuration register, entry into
// sleep and standby on the halt instruction, and the wake and reset paths.
// Assumes the core pulses halt_exec for one cycle when the halt instruction
// retires, and that the interrupt controller, watchdog and DMA controller
// sit on the same clock. The reset and NMI pins are asynchronous.
//
// Strobed register access was decided locally.
`default_nettype none

module pdm_power_ctrl
    import pdm_pkg::*;
#(
    // Settle interval at select code 0; shorten for simulation.
    parameter int SETTLE_BASE_CYC = PDM_SETTLE_BASE_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Register port.
    input  wire logic [27:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Processor core.
    input  wire logic        halt_exec,
    output logic             cpu_halt,
    // Watchdog unit.
    input  wire logic        watchdog_run_enable,
    input  wire logic [2:0]  settle_interval_select,
    output logic             watchdog_clock_only,
    // Interrupt controller.
    input  wire logic        irq_request,
    input  wire logic        irq_source_enable,
    input  wire logic [3:0]  irq_level,
    input  wire logic [3:0]  irq_cpu_mask,
    input  wire logic        nmi_edge_select,
    // DMA controller.
    input  wire logic        dma_addr_error,
    // Pins.
    input  wire logic        external_reset_n,
    input  wire logic        nmi_pin,
    // Clock, peripherals, ports and RAM.
    output logic             clock_stop,
    output logic             periph_halt,
    output logic             port_float,
    output logic             port_hold,
    output logic             ram_retain,
    // Wake and reset causes, one-cycle pulses.
    output logic             wake_irq,
    output logic             wake_dma_error,
    output logic             wake_nmi,
    output logic             power_on_reset,
    output logic             manual_reset,
    // Present power state.
    output logic      [1:0]  power_state
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic res_s1_q;   // First stage, read only by the second.
    logic res_s2_q;   // Synchronised reset pin level.
    logic res_s3_q;   // Previous synchronised level for edge detection.
    logic nmi_s1_q;   // First stage, read only by the second.
    logic nmi_s2_q;   // Synchronised NMI pin level.
    logic nmi_s3_q;   // Previous synchronised level for edge detection.

    // Two flops before any logic looks at a pin; a third for edges.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            res_s1_q <= 1'b1;
            res_s2_q <= 1'b1;
            res_s3_q <= 1'b1;
            nmi_s1_q <= 1'b0;
            nmi_s2_q <= 1'b0;
            nmi_s3_q <= 1'b0;
        end else begin
            res_s1_q <= external_reset_n;
            res_s2_q <= res_s1_q;
            res_s3_q <= res_s2_q;
            nmi_s1_q <= nmi_pin;
            nmi_s2_q <= nmi_s1_q;
            nmi_s3_q <= nmi_s2_q;
        end
    end

    logic res_fall;   // Reset pin has just gone low.
    logic nmi_edge;   // The selected NMI edge has just been seen.

    // edges on clock
    // Edges are taken from synchronised levels only.
    always_comb begin
        res_fall = res_s3_q & ~res_s2_q;
        if (nmi_edge_select) begin
            nmi_edge = ~nmi_s3_q & nmi_s2_q;
        end else begin
            nmi_edge = nmi_s3_q & ~nmi_s2_q;
        end
    end

    // ************************************************************
    // Standby configuration register
    // ************************************************************
    logic       standby_select_q;     // Halt enters standby when set.
    logic       standby_select_d;
    logic       port_float_select_q;  // Ports float in standby when set.
    logic       port_float_select_d;
    logic [7:0] rdata_q;              // Read data, valid one cycle only.
    logic [7:0] rdata_d;
    logic       hit;                  // Address matches the register.

    // Write and read decode; unmapped reads return zero.
    always_comb begin
        hit                 = (reg_addr == PDM_STBY_CFG_ADDR);
        standby_select_d    = standby_select_q;
        port_float_select_d = port_float_select_q;
        rdata_d             = 8'h00;
        if (reg_wr && hit) begin
            // gated standby select
            // Clearing is always allowed; setting needs the watchdog stopped.
            if (!reg_wdata[PDM_STANDBY_SEL_BIT]) begin
                standby_select_d = 1'b0;
            end else if (!watchdog_run_enable) begin
                standby_select_d = 1'b1;
            end
            // gated port float
            // Same gate for the port float select.
            if (!reg_wdata[PDM_PORT_FLOAT_BIT]) begin
                port_float_select_d = 1'b0;
            end else if (!watchdog_run_enable) begin
                port_float_select_d = 1'b1;
            end
        end
        if (reg_rd && hit) begin
            // fixed reserved bits
            // Bit 5 is a constant zero and bits 4..0 constant ones.
            rdata_d                      = {2'b00, 1'b0, PDM_ONES_FIELD};
            rdata_d[PDM_STANDBY_SEL_BIT] = standby_select_q;
            rdata_d[PDM_PORT_FLOAT_BIT]  = port_float_select_q;
        end
    end

    // register reset value
    // The register keeps its value through sleep and standby; only reset or a write clears it.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            standby_select_q    <= PDM_STANDBY_SEL_RST;
            port_float_select_q <= PDM_PORT_FLOAT_RST;
            rdata_q             <= 8'h00;
        end else begin
            standby_select_q    <= standby_select_d;
            port_float_select_q <= port_float_select_d;
            rdata_q             <= rdata_d;
        end
    end

    // ************************************************************
    // Settle timer
    // ************************************************************
    pdm_settle_if settle ();

    logic       settle_start_q;   // One-cycle start to the timer.
    logic       settle_start_d;
    logic [2:0] settle_sel_q;     // Select code latched at standby entry.
    logic [2:0] settle_sel_d;

    assign settle.start    = settle_start_q;
    assign settle.interval = settle_sel_q;

    pdm_settle_timer #(
        .SETTLE_BASE_CYC (SETTLE_BASE_CYC)
    ) u_settle (
        .core_clk (core_clk),
        .reset    (reset),
        .tmr      (settle)
    );

    // ************************************************************
    // Power state machine
    // ************************************************************
    pdm_state_t state_q;          // Present power state.
    pdm_state_t state_d;
    logic       irq_accept;       // Interrupt the core would take now.
    logic       wake_irq_q;
    logic       wake_irq_d;
    logic       wake_dma_q;
    logic       wake_dma_d;
    logic       wake_nmi_q;
    logic       wake_nmi_d;
    logic       por_q;
    logic       por_d;
    logic       mrst_q;
    logic       mrst_d;
    logic       cpu_halt_q;
    logic       cpu_halt_d;
    logic       clk_stop_q;
    logic       clk_stop_d;
    logic       wdt_only_q;
    logic       wdt_only_d;
    logic       float_q;
    logic       float_d;
    logic       hold_q;
    logic       hold_d;
    logic       ram_ret_q;
    logic       ram_ret_d;

    // Next state, causes and the outputs that follow from the next state.
    always_comb begin
        state_d        = state_q;
        wake_irq_d     = 1'b0;
        wake_dma_d     = 1'b0;
        wake_nmi_d     = 1'b0;
        por_d          = 1'b0;
        mrst_d         = 1'b0;
        settle_start_d = 1'b0;
        settle_sel_d   = settle_sel_q;
        irq_accept = irq_request & irq_source_enable & (irq_level > irq_cpu_mask);
        if (res_fall) begin
            // reset wins
            // A reset edge overrides every other cause in the same cycle.
            state_d = PDM_RUN;
            if (nmi_s2_q) begin
                por_d = 1'b1;
            end else begin
                mrst_d = 1'b1;
            end
        end else begin
            case (state_q)
                PDM_RUN: begin
                    if (halt_exec) begin
                        // enter standby
                        // The select code is captured now, as the watchdog set it.
                        if (standby_select_q) begin
                            state_d      = PDM_STANDBY;
                            settle_sel_d = settle_interval_select;
                        end else begin
                            state_d = PDM_SLEEP;
                        end
                    end
                end
                PDM_SLEEP: begin
                    if (nmi_edge) begin
                        state_d    = PDM_RUN;
                        wake_nmi_d = 1'b1;
                    end else if (dma_addr_error) begin
                        state_d    = PDM_RUN;
                        wake_dma_d = 1'b1;
                    end else if (irq_accept) begin
                        state_d    = PDM_RUN;
                        wake_irq_d = 1'b1;
                    end
                end
                PDM_STANDBY: begin
                    // NMI only
                    // Ordinary interrupts and DMA errors are ignored here.
                    if (nmi_edge) begin
                        state_d        = PDM_SETTLE;
                        settle_start_d = 1'b1;
                    end
                end
                PDM_SETTLE: begin
                    // wait for overflow
                    // The chip clock comes back when the count overflows, or earlier on a reset edge.
                    if (settle.done) begin
                        state_d    = PDM_RUN;
                        wake_nmi_d = 1'b1;
                    end
                end
                default: begin
                    state_d = PDM_RUN;
                end
            endcase
        end
        // only core halts
        // Sleep leaves the peripheral clock running; the core stops next cycle.
        cpu_halt_d = (state_d != PDM_RUN);
        clk_stop_d = (state_d == PDM_STANDBY) || (state_d == PDM_SETTLE);
        wdt_only_d = (state_d == PDM_SETTLE);
        float_d = clk_stop_d & port_float_select_q;
        hold_d  = clk_stop_d & ~port_float_select_q;
        // retain RAM
        // Retention blocks RAM writes from the stopped core side.
        ram_ret_d = cpu_halt_d;
    end

    // Registers only.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q        <= PDM_RUN;
            wake_irq_q     <= 1'b0;
            wake_dma_q     <= 1'b0;
            wake_nmi_q     <= 1'b0;
            por_q          <= 1'b0;
            mrst_q         <= 1'b0;
            settle_start_q <= 1'b0;
            settle_sel_q   <= 3'h0;
            cpu_halt_q     <= 1'b0;
            clk_stop_q     <= 1'b0;
            wdt_only_q     <= 1'b0;
            float_q        <= 1'b0;
            hold_q         <= 1'b0;
            ram_ret_q      <= 1'b0;
        end else begin
            state_q        <= state_d;
            wake_irq_q     <= wake_irq_d;
            wake_dma_q     <= wake_dma_d;
            wake_nmi_q     <= wake_nmi_d;
            por_q          <= por_d;
            mrst_q         <= mrst_d;
            settle_start_q <= settle_start_d;
            settle_sel_q   <= settle_sel_d;
            cpu_halt_q     <= cpu_halt_d;
            clk_stop_q     <= clk_stop_d;
            wdt_only_q     <= wdt_only_d;
            float_q        <= float_d;
            hold_q         <= hold_d;
            ram_ret_q      <= ram_ret_d;
        end
    end

    // ************************************************************
    // Outputs, all straight from flops
    // ************************************************************
    assign reg_rdata           = rdata_q;
    assign cpu_halt            = cpu_halt_q;
    assign watchdog_clock_only = wdt_only_q;
    assign clock_stop          = clk_stop_q;
    assign periph_halt         = clk_stop_q;
    assign port_float          = float_q;
    assign port_hold           = hold_q;
    assign ram_retain          = ram_ret_q;
    assign wake_irq            = wake_irq_q;
    assign wake_dma_error      = wake_dma_q;
    assign wake_nmi            = wake_nmi_q;
    assign power_on_reset      = por_q;
    assign manual_reset        = mrst_q;
    assign power_state         = state_q;

endmodule : pdm_power_ctrl

`default_nettype wire

// ### src/pdm_settle_if.sv
// Interface between the power-state controller and the settle timer.
// Assumes both ends run on the same system clock.
`default_nettype none

interface pdm_settle_if;
    logic       start;       // One-cycle request to begin a settle interval.
    logic [2:0] interval;    // Interval select, held steady while counting.
    logic       busy;        // High while the timer counts.
    logic       done;        // One-cycle pulse at overflow.

    modport ctrl  (output start, output interval, input busy, input done);
    modport timer (input start, input interval, output busy, output done);
endinterface : pdm_settle_if

`default_nettype wire

// ### src/pdm_settle_timer.sv
// Settle timer: stands in for the watchdog count that runs alone while
// the oscillator recovers after a standby wake.
// Assumes start arrives from logic on the same clock.
`default_nettype none

module pdm_settle_timer
    import pdm_pkg::*;
#(
    parameter int SETTLE_BASE_CYC = PDM_SETTLE_BASE_CYC
) (
    input  wire logic   core_clk,
    input  wire logic   reset,
    pdm_settle_if.timer tmr
);

    // ************************************************************
    // Counter state
    // ************************************************************
    logic [PDM_SETTLE_CNT_W-1:0] cnt_q;   // Cycles left in the interval.
    logic [PDM_SETTLE_CNT_W-1:0] cnt_d;
    logic                        busy_q;  // Counting.
    logic                        busy_d;
    logic                        done_q;  // Overflow pulse.
    logic                        done_d;

    // Next-state logic: load base shifted by the select code, count down.
    always_comb begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (tmr.start) begin
            // Load one less than the interval so that done lands exactly on it.
            cnt_d  = PDM_SETTLE_CNT_W'((SETTLE_BASE_CYC << tmr.interval) - 1);
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (cnt_q == '0) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    // Registers only.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign tmr.busy = busy_q;
    assign tmr.done = done_q;

endmodule : pdm_settle_timer

`default_nettype wire
